// File: design/baseline_instr_decode_pc.sv
// fetch address sequencer, instruction decode and execute core with Avalon-MM registers
//
// What this block does
// - smallest variant: 9-bit counter, 512 words
// - mid variant: 10-bit counter, 1K words
// - largest variant: 11-bit counter, 2K words
// - addresses past memory wrap, never error
// - reset starts fetch at last word
// - no-operation at reset vector continues at zero
// - page bits extend addresses above 512 words
// - bank pointer bits pick the data bank
// - each instruction is one 12-bit word
// - byte format: opcode, destination, file address
// - destination 0 writes accumulator, 1 file
// - file address picks one of 32
// - bit format: opcode, bit number, file
// - literal format: opcode and 8-bit literal
// - jump format: opcode and 9-bit target
// - don't-care bits never change decoding
// - one cycle; two when skipping or branching
// - instruction cycle is four clock periods
// - copy accumulator to file, one cycle
// - return loads literal, pops stack, two cycles
//
// Added by the designer: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`include "core_params.svh"
module baseline_instr_decode_pc import core_pkg::*; #(
   parameter int PC_W = 9, // 9, 10 or 11 for the three memory sizes
   parameter int BANK_W = 2 // bank bits used from the bank pointer
) (
   input wire logic CLK_IN,
   input wire logic RST_IN,
   output logic [PC_W-1:0] PMEM_ADDR_OUT,
   input wire logic [11:0] PMEM_DATA_IN,
   output logic INSTR_CYCLE_OUT,
   input wire logic [2:0] AVS_ADDRESS_IN,
   input wire logic AVS_READ_IN,
   input wire logic AVS_WRITE_IN,
   input wire logic [31:0] AVS_WRITEDATA_IN,
   input wire logic [3:0] AVS_BYTEENABLE_IN,
   output logic [31:0] AVS_READDATA_OUT,
   output logic AVS_WAITREQUEST_OUT
);
   localparam logic [PC_W-1:0] RESET_VEC = '1; // last program word
   localparam logic [PC_W-1:0] PC_ONE = {{(PC_W-1){1'b0}}, 1'b1};
   localparam int RAM_AW = BANK_W + 5;

   // phase and sequencing
   logic [1:0] q; // phase within an instruction cycle
   logic cyc_end; // last phase of the cycle
   logic step; // cycle end while the core runs
   seq_state_t state; // fill after reset or a discarded fetch, else execute
   logic [PC_W-1:0] program_counter; // fetch address
   logic [11:0] ir; // instruction under execution
   logic [7:0] acc; // accumulator
   // software-held registers
   logic run; // core advances only while set
   logic [1:0] page_sel; // program page bits
   logic [7:0] bank_select_pointer; // data bank pointer
   logic [PC_W-1:0] stack_top_entry; // return address
   // decode and execute signals
   instr_fields_t f; // fields of ir
   logic [PC_W-1:0] pc_inc; // counter plus one, wraps naturally
   logic [10:0] jump_full; // page bits joined to the jump target
   logic [PC_W-1:0] jump_pc; // jump target cut to the implemented size
   logic [RAM_AW-1:0] ram_addr; // banked file address
   logic [7:0] ram_rdata; // file data read at the start of the cycle
   logic file_wr; // file write at cycle end
   logic [7:0] file_wdata; // file write data
   logic acc_wr; // accumulator write at cycle end
   logic [7:0] next_acc; // accumulator write data
   logic redirect; // counter reloaded, fetched word discarded
   logic skip_taken; // conditional test true, fetched word discarded
   logic tested_bit; // addressed bit of the file register
   logic [PC_W-1:0] next_pc;
   logic [11:0] next_ir;
   seq_state_t next_state;
   // bus
   logic bus_req; // read or write held by the master
   logic bus_wr; // write accepted on this edge
   logic [31:0] rd_mux; // read value of the addressed word
   logic [31:0] wr_merged; // write data merged by byte lanes

   // the field splitter is purely combinational
   instr_field_split u_split (
      .word_in(ir),
      .fields_out(f)
   );

   // data file: upper bits from the bank pointer, lower from the instruction
   assign ram_addr = {bank_select_pointer[`BANK_LO +: BANK_W], f.file_addr};

   file_ram #(
      .AW(RAM_AW),
      .DW(8)
   ) u_ram (
      .clk_in(CLK_IN),
      .rst_in(RST_IN),
      .wr_en_in(file_wr),
      .addr_in(ram_addr),
      .wr_data_in(file_wdata),
      .rd_data_out(ram_rdata)
   );

   // phase divider: one instruction cycle per four clocks; free running so the
   // bus can still stop the core without tearing a cycle in half
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         q <= 2'h0;
      end else begin
         q <= q + 2'h1;
      end
   end
   assign cyc_end = (q == `Q_LAST);
   assign step = cyc_end & run;

   // address arithmetic; the counter width alone gives the wraparound
   assign pc_inc = program_counter + PC_ONE;
   assign jump_full = {page_sel, f.target};
   assign jump_pc = jump_full[PC_W-1:0];
   assign tested_bit = ram_rdata[f.bit_num];

   // execute: what the instruction in ir does at the end of its cycle
   always_comb begin
      file_wr = 1'b0;
      file_wdata = ram_rdata;
      acc_wr = 1'b0;
      next_acc = acc;
      redirect = 1'b0;
      skip_taken = 1'b0;
      if (state == ST_EXEC) begin
         unique case (f.kind)
            OP_COPY_ACC_TO_FILE: begin
               file_wr = 1'b1;
               file_wdata = acc;
            end
            OP_CLEAR_ACC: begin
               acc_wr = 1'b1;
               next_acc = 8'h00;
            end
            OP_CLEAR_FILE: begin
               file_wr = 1'b1;
               file_wdata = 8'h00;
            end
            OP_MOVE_FILE: begin
               file_wr = f.dest;
               acc_wr = ~f.dest;
               next_acc = ram_rdata;
            end
            OP_BIT_CLEAR: begin
               file_wr = 1'b1;
               file_wdata = ram_rdata & ~(8'h01 << f.bit_num);
            end
            OP_BIT_SET: begin
               file_wr = 1'b1;
               file_wdata = ram_rdata | (8'h01 << f.bit_num);
            end
            OP_SKIP_IF_CLEAR: begin
               skip_taken = ~tested_bit;
            end
            OP_SKIP_IF_SET: begin
               skip_taken = tested_bit;
            end
            OP_RETURN_LOAD_LITERAL: begin
               acc_wr = 1'b1;
               next_acc = f.literal;
               redirect = 1'b1;
            end
            OP_LOAD_LITERAL: begin
               acc_wr = 1'b1;
               next_acc = f.literal;
            end
            OP_JUMP: begin
               redirect = 1'b1;
            end
            OP_NONE: begin
               redirect = 1'b0; // no-operation and unused codes
            end
         endcase
      end
      // side effects only land on the last phase of a running cycle
      file_wr = file_wr & step;
      acc_wr = acc_wr & step;
   end

   // next fetch address, next instruction and next state
   always_comb begin
      next_pc = pc_inc;
      next_ir = PMEM_DATA_IN;
      next_state = ST_EXEC;
      unique case (state)
         ST_FILL: begin
            next_pc = pc_inc;
         end
         ST_EXEC: begin
            if (redirect) begin
               // a changed counter costs a second cycle: the prefetched word is dropped
               next_ir = `NOP_WORD;
               next_state = ST_FILL;
               if (f.kind == OP_JUMP) begin
                  next_pc = jump_pc;
               end else begin
                  next_pc = stack_top_entry;
               end
            end else if (skip_taken) begin
               next_ir = `NOP_WORD;
               next_state = ST_FILL;
            end
         end
      endcase
   end

   // sequencer registers move once per running instruction cycle
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         program_counter <= RESET_VEC;
         ir <= `NOP_WORD;
         state <= ST_FILL; // first cycle only fetches
      end else if (step) begin
         program_counter <= next_pc;
         ir <= next_ir;
         state <= next_state;
      end
   end
   assign PMEM_ADDR_OUT = program_counter;

   // accumulator
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         acc <= 8'h00;
      end else if (acc_wr) begin
         acc <= next_acc;
      end
   end

   // cycle strobe for the outside, one clock after the boundary
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         INSTR_CYCLE_OUT <= 1'b0;
      end else begin
         INSTR_CYCLE_OUT <= step;
      end
   end

   // bus slave: every request waits exactly one clock, so the answer is
   // fixed and the master never sees a stale read
   assign bus_req = AVS_READ_IN | AVS_WRITE_IN;
   assign bus_wr = AVS_WRITE_IN & ~AVS_WAITREQUEST_OUT;

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         AVS_WAITREQUEST_OUT <= 1'b1;
      end else if (bus_req & AVS_WAITREQUEST_OUT) begin
         AVS_WAITREQUEST_OUT <= 1'b0;
      end else begin
         AVS_WAITREQUEST_OUT <= 1'b1;
      end
   end

   // read multiplexer; unmapped words read as zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (AVS_ADDRESS_IN)
         `REG_CTRL: rd_mux[`CTRL_RUN_BIT] = run;
         `REG_PAGE: rd_mux[1:0] = page_sel;
         `REG_BANK: rd_mux[7:0] = bank_select_pointer;
         `REG_STACK: rd_mux[PC_W-1:0] = stack_top_entry;
         `REG_PC: rd_mux[PC_W-1:0] = program_counter;
         `REG_ACC: rd_mux[7:0] = acc;
         `REG_STAT: rd_mux[5:0] = {state, f.kind};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // read data captured while waitrequest is high, standing when it drops
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         AVS_READDATA_OUT <= 32'h0000_0000;
      end else if (AVS_READ_IN & AVS_WAITREQUEST_OUT) begin
         AVS_READDATA_OUT <= rd_mux;
      end
   end

   // byte-lane merge of write data onto the current value
   always_comb begin
      wr_merged = rd_mux;
      for (int i = 0; i < 4; i++) begin
         if (AVS_BYTEENABLE_IN[i]) begin
            wr_merged[8*i +: 8] = AVS_WRITEDATA_IN[8*i +: 8];
         end
      end
   end

   // software-held registers; writes to read-only words are dropped
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         run <= `CTRL_RESET;
         page_sel <= `PAGE_RESET;
         bank_select_pointer <= `BANK_RESET;
         stack_top_entry <= RESET_VEC;
      end else if (bus_wr) begin
         unique case (AVS_ADDRESS_IN)
            `REG_CTRL: run <= wr_merged[`CTRL_RUN_BIT];
            `REG_PAGE: page_sel <= wr_merged[1:0];
            `REG_BANK: bank_select_pointer <= wr_merged[7:0];
            `REG_STACK: stack_top_entry <= wr_merged[PC_W-1:0];
            default: run <= run;
         endcase
      end
   end

   // checks next to the logic
   AST_CYCLE_FOUR: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      cyc_end |=> !cyc_end [*3] ##1 cyc_end) else $error("cycle not four clocks");
   AST_RESET_VECTOR: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      $past(RST_IN) |-> PMEM_ADDR_OUT == RESET_VEC && state == ST_FILL) else $error("bad reset vector");
   AST_WRAP_TO_ZERO: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      step && state == ST_FILL && program_counter == RESET_VEC |=> program_counter == '0)
      else $error("no wrap to zero");
   AST_PC_ADVANCE: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      step && !(redirect && state == ST_EXEC) |=> program_counter == $past(pc_inc))
      else $error("counter did not advance");
   AST_JUMP_TARGET: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      step && state == ST_EXEC && f.kind == OP_JUMP |=>
      program_counter == $past(jump_pc) && state == ST_FILL && ir == `NOP_WORD)
      else $error("jump target wrong");
   AST_RETURN_LOAD: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      step && state == ST_EXEC && f.kind == OP_RETURN_LOAD_LITERAL && run |=>
      (acc == $past(f.literal) && program_counter == $past(stack_top_entry) && state == ST_FILL)
      ##4 (state == ST_EXEC || !run)) else $error("return timing wrong");
   AST_COPY_ACC: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      step && state == ST_EXEC && f.kind == OP_COPY_ACC_TO_FILE |->
      file_wr && file_wdata == acc && !acc_wr ##1 state == ST_EXEC) else $error("copy wrong");
   AST_DEST_SELECT: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      step && state == ST_EXEC && f.kind == OP_MOVE_FILE |-> file_wr == f.dest && acc_wr == !f.dest)
      else $error("destination wrong");
   AST_SKIP_TWO: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      step && state == ST_EXEC && skip_taken |=> state == ST_FILL && ir == `NOP_WORD)
      else $error("skip not two cycles");
   AST_BUS_ANSWER: assert property (@(posedge CLK_IN) disable iff (RST_IN)
      bus_req && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT)
      else $error("bus answer late");
endmodule : baseline_instr_decode_pc

// File: design/core_params.svh
// timing counts, bus offsets, field positions and opcode codes of the decode/fetch core
`ifndef CORE_PARAMS_SVH
`define CORE_PARAMS_SVH
// oscillator periods per instruction cycle and the last phase index
`define Q_PER_CYCLE 4
`define Q_LAST 2'h3
// register word indices (byte address is four times the index)
`define REG_CTRL 3'h0
`define REG_PAGE 3'h1
`define REG_BANK 3'h2
`define REG_STACK 3'h3
`define REG_PC 3'h4
`define REG_ACC 3'h5
`define REG_STAT 3'h6
// control register layout and reset values
`define CTRL_RUN_BIT 0
`define CTRL_RESET 1'h1
`define PAGE_RESET 2'h0
`define BANK_RESET 8'h00
`define BANK_HI 6
`define BANK_LO 5
// instruction field positions
`define OPC6_HI 11
`define OPC6_LO 6
`define DEST_BIT 5
`define FILE_HI 4
`define BITN_HI 7
`define BITN_LO 5
`define JUMP_LO 9
// opcode codes
`define NOP_WORD 12'h000
`define OPC7_COPY 7'h01
`define OPC7_CLR_ACC 7'h02
`define OPC7_CLR_FILE 7'h03
`define OPC6_MOVE_FILE 6'h08
`define OPC4_BIT_CLEAR 4'h4
`define OPC4_BIT_SET 4'h5
`define OPC4_SKIP_CLEAR 4'h6
`define OPC4_SKIP_SET 4'h7
`define OPC4_RETURN_LIT 4'h8
`define OPC4_LOAD_LIT 4'hC
`define OPC3_JUMP 3'h5
`endif

// File: design/core_pkg.sv
// types shared by the decode/fetch core and its field splitter
package core_pkg;
   // operation classes found by the field splitter
   typedef enum logic [3:0] {
      OP_NONE = 4'h0,
      OP_COPY_ACC_TO_FILE = 4'h1,
      OP_CLEAR_ACC = 4'h2,
      OP_CLEAR_FILE = 4'h3,
      OP_MOVE_FILE = 4'h4,
      OP_BIT_CLEAR = 4'h5,
      OP_BIT_SET = 4'h6,
      OP_SKIP_IF_CLEAR = 4'h7,
      OP_SKIP_IF_SET = 4'h8,
      OP_RETURN_LOAD_LITERAL = 4'h9,
      OP_LOAD_LITERAL = 4'hA,
      OP_JUMP = 4'hB
   } op_kind_t;
   // all operand fields of one instruction word
   typedef struct packed {
      op_kind_t kind;
      logic [5:0] opcode;
      logic dest;
      logic [4:0] file_addr;
      logic [2:0] bit_num;
      logic [7:0] literal;
      logic [8:0] target;
   } instr_fields_t;
   // sequencer states, one-hot
   typedef enum logic [1:0] {
      ST_FILL = 2'h1,
      ST_EXEC = 2'h2
   } seq_state_t;
endpackage : core_pkg

// File: design/file_ram.sv
// banked data register file with a registered read port
`timescale 1ns/1ps
module file_ram #(
   parameter int AW = 7,
   parameter int DW = 8
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic wr_en_in,
   input wire logic [AW-1:0] addr_in,
   input wire logic [DW-1:0] wr_data_in,
   output logic [DW-1:0] rd_data_out
);
   logic [DW-1:0] mem [0:(1<<AW)-1]; // storage, contents undefined at power-up

   // write port, one word per clock
   always_ff @(posedge clk_in) begin
      if (wr_en_in) begin
         mem[addr_in] <= wr_data_in;
      end
   end

   // read port, data one clock after the address
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rd_data_out <= '0;
      end else begin
         rd_data_out <= mem[addr_in];
      end
   end
endmodule : file_ram

// File: design/instr_field_split.sv
// splits a 12-bit instruction word into its operand fields and class
`timescale 1ns/1ps
`include "core_params.svh"
module instr_field_split import core_pkg::*; (
   input wire logic [11:0] word_in,
   output instr_fields_t fields_out
);
   // every format is sliced at once; the class picks which fields matter
   always_comb begin
      fields_out.opcode = word_in[`OPC6_HI:`OPC6_LO];
      fields_out.dest = word_in[`DEST_BIT];
      fields_out.file_addr = word_in[`FILE_HI:0];
      fields_out.bit_num = word_in[`BITN_HI:`BITN_LO];
      fields_out.literal = word_in[7:0];
      fields_out.target = word_in[8:0];
      fields_out.kind = OP_NONE; // unknown codes run as no-operation
      // don't-care bits are simply never compared
      if (word_in[11:9] == `OPC3_JUMP) begin
         fields_out.kind = OP_JUMP;
      end else if (word_in[11:8] == `OPC4_RETURN_LIT) begin
         fields_out.kind = OP_RETURN_LOAD_LITERAL;
      end else if (word_in[11:8] == `OPC4_LOAD_LIT) begin
         fields_out.kind = OP_LOAD_LITERAL;
      end else if (word_in[11:8] == `OPC4_BIT_CLEAR) begin
         fields_out.kind = OP_BIT_CLEAR;
      end else if (word_in[11:8] == `OPC4_BIT_SET) begin
         fields_out.kind = OP_BIT_SET;
      end else if (word_in[11:8] == `OPC4_SKIP_CLEAR) begin
         fields_out.kind = OP_SKIP_IF_CLEAR;
      end else if (word_in[11:8] == `OPC4_SKIP_SET) begin
         fields_out.kind = OP_SKIP_IF_SET;
      end else if (word_in[11:6] == `OPC6_MOVE_FILE) begin
         fields_out.kind = OP_MOVE_FILE;
      end else if (word_in[11:5] == `OPC7_COPY) begin
         fields_out.kind = OP_COPY_ACC_TO_FILE;
      end else if (word_in[11:5] == `OPC7_CLR_FILE) begin
         fields_out.kind = OP_CLEAR_FILE;
      end else if (word_in[11:5] == `OPC7_CLR_ACC) begin
         fields_out.kind = OP_CLEAR_ACC;
      end
   end
endmodule : instr_field_split

// File: tb/baseline_instr_decode_pc_bench.sv
// self-checking bench for the fetch and decode core and its register port
`timescale 1ns/1ps
module baseline_instr_decode_pc_bench;
   logic clk;
   logic rst;
   logic [8:0] pmem_addr; // fetch address of the small variant
   logic [11:0] pmem_data;
   logic cyc; // instruction cycle pulse
   logic [10:0] wide_addr; // fetch address of the large variant
   logic [9:0] mid_addr; // fetch address of the mid variant
   logic [11:0] idle_word; // clear-accumulator word with wandering loose bits for the larger variants
   logic [2:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [31:0] rd_q[$]; // expected read data, oldest first
   logic [8:0] fa_q[$]; // expected fetch address after each cycle end
   logic [31:0] seed; // xorshift state
   int mismatches;
   int compares;
   int gap; // clocks since the last cycle pulse
   int pulses; // cycle pulses compared so far
   bit seen;
   // program image as {address, word}: literal, copy, clear with loose bits, skip, jump, return, bit clear
   logic [20:0] image [11] = '{{9'h000, 12'hC5A}, {9'h001, 12'h023}, {9'h002, 12'h05F}, {9'h003, 12'h223},
      {9'h004, 12'h7C3}, {9'h005, 12'hC11}, {9'h006, 12'hA10}, {9'h010, 12'h83C}, {9'h020, 12'h423},
      {9'h021, 12'h203}, {9'h022, 12'hA22}};
   // addresses after each cycle end; 005 is fetched but skipped, each redirect costs a fill cycle
   logic [8:0] walk [16] = '{9'h000, 9'h001, 9'h002, 9'h003, 9'h004, 9'h005, 9'h006, 9'h007, 9'h010,
      9'h011, 9'h020, 9'h021, 9'h022, 9'h023, 9'h022, 9'h023};

   baseline_instr_decode_pc #(.PC_W(9)) dut_u (.CLK_IN(clk), .RST_IN(rst),
      .PMEM_ADDR_OUT(pmem_addr), .PMEM_DATA_IN(pmem_data), .INSTR_CYCLE_OUT(cyc),
      .AVS_ADDRESS_IN(avs_address), .AVS_READ_IN(avs_read), .AVS_WRITE_IN(avs_write),
      .AVS_WRITEDATA_IN(avs_writedata), .AVS_BYTEENABLE_IN(avs_byteenable),
      .AVS_READDATA_OUT(avs_readdata), .AVS_WAITREQUEST_OUT(avs_waitrequest));
   // larger variants share the bus and fetch only clear-accumulator words, so their counters simply count up
   baseline_instr_decode_pc #(.PC_W(11)) dut_wide_u (.CLK_IN(clk), .RST_IN(rst),
      .PMEM_ADDR_OUT(wide_addr), .PMEM_DATA_IN(idle_word), .INSTR_CYCLE_OUT(),
      .AVS_ADDRESS_IN(avs_address), .AVS_READ_IN(avs_read), .AVS_WRITE_IN(avs_write),
      .AVS_WRITEDATA_IN(avs_writedata), .AVS_BYTEENABLE_IN(avs_byteenable),
      .AVS_READDATA_OUT(), .AVS_WAITREQUEST_OUT());
   baseline_instr_decode_pc #(.PC_W(10)) dut_mid_u (.CLK_IN(clk), .RST_IN(rst),
      .PMEM_ADDR_OUT(mid_addr), .PMEM_DATA_IN(idle_word), .INSTR_CYCLE_OUT(),
      .AVS_ADDRESS_IN(avs_address), .AVS_READ_IN(avs_read), .AVS_WRITE_IN(avs_write),
      .AVS_WRITEDATA_IN(avs_writedata), .AVS_BYTEENABLE_IN(avs_byteenable),
      .AVS_READDATA_OUT(), .AVS_WAITREQUEST_OUT());
   prog_mem_model mem_u (.clk_in(clk), .addr_in(pmem_addr), .data_out(pmem_data));

   // 25 MHz clock
   always #20 clk = ~clk;

   // loose bits of the clear-accumulator word walk every clock; decoding must not notice them
   always @(posedge clk) begin
      if (rst) idle_word <= 12'h040;
      else idle_word <= {7'h02, ~idle_word[0], idle_word[4:1]};
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   task automatic check(input logic [31:0] exp, input logic [31:0] got, input string what);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: %s is %h, expected %h", $time, what, got, exp);
      end
   endtask : check

   // holds the request through each rising edge until waitrequest is sampled low there; only the watchdog ends a hang
   task automatic bus_wait();
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
   endtask : bus_wait

   task automatic bus_write(input logic [2:0] a, input logic [31:0] d, input logic [3:0] be);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= 1'b1;
      bus_wait();
      avs_write <= 1'b0;
      @(posedge clk);
   endtask : bus_write

   task automatic bus_read(input logic [2:0] a, input logic [31:0] exp);
      rd_q.push_back(exp);
      avs_address <= a;
      avs_read <= 1'b1;
      bus_wait();
      avs_read <= 1'b0;
      @(posedge clk);
   endtask : bus_read

   task automatic conclude();
      $display("counts: %0d compares, %0d mismatches", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : conclude

   // compares each answer with the oldest note as it appears; sampling on the falling edge keeps clear of edge races
   always @(negedge clk) begin
      if (rst) begin
         gap = 0;
         seen = 0;
         pulses = 0;
      end else begin
         gap++;
         if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && rd_q.size() > 0) begin
            check(rd_q.pop_front(), avs_readdata, "read data");
         end
         if (cyc === 1'b1) begin
            if (seen) check(32'h4, 32'(gap), "cycle length");
            if (fa_q.size() > 0) begin
               check({23'h0, fa_q.pop_front()}, {23'h0, pmem_addr}, "fetch address");
               check(32'(pulses), {21'h0, wide_addr}, "wide fetch address");
               check(32'(pulses), {22'h0, mid_addr}, "mid fetch address");
               pulses++;
            end
            gap = 0;
            seen = 1;
         end
      end
   end

   // the run needs some 160 clocks; far beyond that means a hang
   initial begin
      #(40 * 3000);
      mismatches++;
      $display("Error at %0t: watchdog expired", $time);
      conclude();
   end

   initial begin
      int n;
      clk = 1'b0;
      rst = 1'b1;
      avs_address = 3'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
      seed = 32'h0000_8079;
      mismatches = 0;
      compares = 0;
      #1;
      foreach (image[i]) mem_u.mem[image[i][20:12]] = image[i][11:0];
      foreach (walk[i]) fa_q.push_back(walk[i]);
      repeat (16) @(posedge clk);
      check(32'h1FF, {23'h0, pmem_addr}, "reset vector");
      check(32'h7FF, {21'h0, wide_addr}, "wide reset vector");
      check(32'h3FF, {22'h0, mid_addr}, "mid reset vector");
      rst <= 1'b0;
      $display("test reset done");
      // reset values, unmapped index, then a return address for the program
      bus_read(3'h0, 32'h1);
      bus_read(3'h1, 32'h0);
      bus_read(3'h2, 32'h0);
      bus_read(3'h3, 32'h1FF);
      bus_read(3'h7, 32'h0);
      bus_write(3'h3, 32'h20, 4'hF);
      bus_read(3'h3, 32'h20);
      n = 0;
      while (fa_q.size() > 0 && n < 400) begin
         @(posedge clk);
         n++;
      end
      check(32'h0, 32'(fa_q.size()), "fetch walk left over");
      $display("test fetch done");
      // freeze the core and read the accumulator left by the program
      bus_write(3'h0, 32'h0, 4'hF);
      bus_read(3'h5, 32'h58);
      repeat (4) begin
         seed = xs(seed);
         bus_write(3'h2, seed, 4'hF);
         bus_write(3'h2, ~seed, 4'h0);
         bus_read(3'h2, {24'h0, seed[7:0]});
         bus_write(3'h5, seed, 4'hF);
         bus_read(3'h5, 32'h58);
         bus_write(3'h7, seed, 4'hF);
         bus_read(3'h7, 32'h0);
      end
      $display("test registers done");
      conclude();
   end
endmodule : baseline_instr_decode_pc_bench

// File: tb/prog_mem_model.sv
// program memory model that answers each fetch address after a set latency
`timescale 1ns/1ps
module prog_mem_model #(
   parameter int AW = 9, // address width of the fetch port
   parameter int LAT = 2 // clocks after an address change before the word is due
) (
   input wire logic clk_in,
   input wire logic [AW-1:0] addr_in,
   output logic [11:0] data_out
);
   logic [11:0] mem [0:(1<<AW)-1]; // one whole 12-bit word per address
   logic [AW-1:0] last_addr; // address seen at the previous edge
   int age; // clocks since the address last moved
   // unused words read as no-operation
   initial begin
      foreach (mem[i]) mem[i] = 12'h000;
      data_out = 12'h000;
      last_addr = '0;
      age = 0;
   end
   // until the word is due the bus inverts itself every clock, so the old word and its inverse alternate
   always @(posedge clk_in) begin
      last_addr <= addr_in;
      if (addr_in !== last_addr) age <= 0;
      else if (age < LAT) age <= age + 1;
      if (addr_in === last_addr && age >= LAT - 1) data_out <= mem[addr_in];
      else data_out <= ~data_out;
   end
endmodule : prog_mem_model
